// ===== include/btc_defines.svh
`ifndef BTC_DEFINES_SVH
`define BTC_DEFINES_SVH
`define BTC_GROUP_W      16
`define BTC_GROUP_N      5
`define BTC_REC_W        80
`define BTC_CH_WR_N      4
`define BTC_CH_RWE_N     5
`define BTC_CH_DIAG0     10
`define BTC_CH_DIAG1     12
`define BTC_REC_RESET    80'h0
`define BTC_CLASS_READ   3'h0
`define BTC_CLASS_WRITE  3'h1
`define BTC_CLASS_IFETCH 3'h2
`define BTC_CLASS_DLOAD  3'h3
`define BTC_CLASS_TERR   3'h4
`define BTC_EV_READ      0
`define BTC_EV_WRITE     1
`define BTC_EV_TERR      2
`define BTC_EV_SUBST     3
`define BTC_EV_N         4
`endif

// ===== include/btc_pkg.sv
package btc_pkg;
  typedef struct packed {
    logic [31:0] bus_ad;
    logic [27:0] addr_hi;
    logic [1:0]  word_idx;
    logic [1:0]  byte_lane_enables;
    logic        write_n;
    logic        read_n;
    logic        read_word_enable_n;
    logic [1:0]  diag;
  } btc_cpu_t;
  typedef struct packed {
    logic [15:0] g5;
    logic [15:0] g4;
    logic [15:0] g3;
    logic [15:0] g2;
    logic [15:0] g1;
  } btc_record_t;
  typedef enum logic [1:0] {
    BTC_IDLE,
    BTC_READ,
    BTC_WRITE
  } btc_state_t;
endpackage : btc_pkg

// ===== sim/btc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module btc_cpu_model (
  input  wire logic         core_clk_in,
  output btc_pkg::btc_cpu_t cpu_out
);
  import btc_pkg::*;
  logic [31:0] last_bus;
  initial begin
    cpu_out = '1;
    last_bus = '1;
  end
  // released bus shows the inverse of the last value
  task automatic idle();
    @(posedge core_clk_in);
    cpu_out.bus_ad <= ~last_bus;
    cpu_out.read_n <= 1'b1;
    cpu_out.write_n <= 1'b1;
    cpu_out.read_word_enable_n <= 1'b1;
  endtask : idle
  // read strobe held, one enable pulse per word
  task automatic rd(input logic [31:0] a, d, input logic [1:0] dg, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_in);
      cpu_out.read_n <= 1'b0;
      cpu_out.addr_hi <= a[31:4];
      cpu_out.word_idx <= i[1:0];
      cpu_out.byte_lane_enables <= a[1:0];
      cpu_out.diag <= dg;
      cpu_out.bus_ad <= d ^ i;
      cpu_out.read_word_enable_n <= 1'b0;
      last_bus = d ^ i;
      @(posedge core_clk_in);
      @(posedge core_clk_in);
      cpu_out.read_word_enable_n <= 1'b1;
    end
    idle();
  endtask : rd
  // enable held low through the burst, word index steps
  task automatic rd_held(input logic [31:0] a, d, input logic [1:0] dg);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_in);
      cpu_out.read_n <= 1'b0;
      cpu_out.addr_hi <= a[31:4];
      cpu_out.word_idx <= i[1:0];
      cpu_out.byte_lane_enables <= a[1:0];
      cpu_out.diag <= dg;
      cpu_out.bus_ad <= d ^ i;
      cpu_out.read_word_enable_n <= 1'b0;
      last_bus = d ^ i;
      @(posedge core_clk_in);
    end
    idle();
  endtask : rd_held
  // write strobe low two cycles, data held past its rising edge
  task automatic wr(input logic [31:0] a, d, input logic rwe_n);
    @(posedge core_clk_in);
    cpu_out.write_n <= 1'b0;
    cpu_out.addr_hi <= a[31:4];
    cpu_out.word_idx <= a[3:2];
    cpu_out.byte_lane_enables <= a[1:0];
    cpu_out.diag <= 2'h0;
    cpu_out.bus_ad <= d;
    cpu_out.read_word_enable_n <= rwe_n;
    last_bus = d;
    repeat (2) @(posedge core_clk_in);
    cpu_out.write_n <= 1'b1;
    idle();
  endtask : wr
endmodule : btc_cpu_model
`default_nettype wire

// ===== sim/tb_bus_trace_capture.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bus_trace_capture;
  import btc_pkg::*;
  logic core_clk_in = 0;
  logic reset_in = 1;
  logic [31:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, lfsr = 32'h404e;
  logic reg_wr_in = 0, reg_rd_in = 0, record_valid_out, irq_out, subst_en = 0;
  logic [2:0] class_out;
  btc_cpu_t cpu_in;
  btc_record_t record_out, eq_rec[$];
  logic [2:0] eq_cls[$];
  int mismatches = 0, comparisons = 0;
  always #2 core_clk_in = ~core_clk_in;
  btc_cpu_model cpu (.core_clk_in(core_clk_in), .cpu_out(cpu_in));
  btc_capture dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .cpu_in(cpu_in),
    .subst_strobe_en_in(subst_en), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .record_out(record_out), .class_out(class_out), .record_valid_out(record_valid_out),
    .irq_out(irq_out));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  function automatic btc_record_t exp_rec(input logic [31:0] a, d, input logic [1:0] wi, be,
                                          dg, input logic wn, rn);
    return {3'h0, dg[1], 1'b0, dg[0], 4'h0, rn, wn, 4'h0, d, a[31:16], a[15:4], wi, be};
  endfunction : exp_rec
  task automatic fail(input string s);
    mismatches++;
    $display("mismatch at %0t: %s", $time, s);
  endtask : fail
  task automatic chk32(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) fail("register or irq value");
  endtask : chk32
  task automatic chk_rec();
    btc_record_t r;
    logic [2:0] c;
    comparisons++;
    if (eq_rec.size() == 0) fail("unexpected record");
    else begin
      r = eq_rec.pop_front();
      c = eq_cls.pop_front();
      if (record_out !== r || class_out !== c) fail("record or class");
    end
  endtask : chk_rec
  always @(negedge core_clk_in) if (record_valid_out === 1'b1) chk_rec();
  task automatic reg_wr(input logic [31:0] a, d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [31:0] a, m, e);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk32(reg_rdata_out & m, e);
  endtask : reg_rd
  task automatic irq_is(input logic e);
    repeat (2) @(posedge core_clk_in);
    #1 chk32({31'h0, irq_out}, {31'h0, e});
  endtask : irq_is
  task automatic do_rd(input logic [1:0] dg, input bit held = 1'b0);
    logic [31:0] a, d;
    a = rnd();
    d = rnd();
    for (int i = 0; i < 4; i++) begin
      eq_rec.push_back(exp_rec(a, d ^ i, i[1:0], a[1:0], dg, 1'b1, 1'b0));
      eq_cls.push_back(dg[1] ? (dg[0] ? 3'h2 : 3'h3) : 3'h0);
    end
    if (held) cpu.rd_held(a, d, dg);
    else cpu.rd(a, d, dg, 4);
  endtask : do_rd
  task automatic do_wr(input logic rwe_n);
    logic [31:0] a, d;
    a = rnd();
    d = rnd();
    eq_rec.push_back(exp_rec(a, d, a[3:2], a[1:0], 2'h0, 1'b0, rwe_n));
    eq_cls.push_back(rwe_n ? 3'h1 : 3'h4);
    cpu.wr(a, d, rwe_n);
  endtask : do_wr
  task automatic end_of_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    #80000;
    fail("watchdog");
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge core_clk_in);
    reset_in <= 1'b0;
    reg_rd(32'h0, '1, 32'h0);
    reg_rd(32'h4, '1, 32'h0);
    for (int k = 0; k < 4; k++) do_rd(k[1:0]);
    repeat (3) @(posedge core_clk_in);
    $display("test burst reads done");
    reg_rd(32'h0, 32'h1, 32'h1);
    irq_is(1'b0);
    reg_wr(32'h4, 32'h7);
    reg_rd(32'h4, 32'h7, 32'h7);
    irq_is(1'b1);
    reg_wr(32'h8, 32'hf);
    reg_wr(32'h0, 32'hf);
    reg_rd(32'h0, '1, 32'h0);
    irq_is(1'b0);
    reg_rd(32'h40, '1, 32'h0);
    $display("test interrupts done");
    do_wr(1'b1);
    reg_rd(32'h0, 32'h6, 32'h2);
    irq_is(1'b1);
    do_wr(1'b0);
    do_rd(2'b11);
    do_wr(1'b1);
    repeat (3) @(posedge core_clk_in);
    reg_rd(32'h0, 32'h4, 32'h4);
    reg_rd(32'hc, 32'h7, 32'h1);
    @(posedge core_clk_in);
    subst_en <= 1'b1;
    do_rd(2'b10, 1'b1);
    subst_en <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    reg_rd(32'h0, 32'h8, 32'h8);
    reg_rd(32'hc, 32'h7, 32'h3);
    chk32(eq_rec.size(), 32'h0);
    $display("test writes done");
    end_of_test();
  end
endmodule : tb_bus_trace_capture
`default_nettype wire

// ===== verilog/btc_capture.sv
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "btc_defines.svh"
// What this block does
// - samples are taken on the read-word enable and the write strobe, not the read strobe.
// - a write is sampled on the rising edge of the write strobe.
// - each record holds the write strobe level, which classes it as read or write.
// - each record holds the read-word enable level so a false write trigger is recognised.
// - the read sample never comes from transfer-done ored with the read-word enable.
// - the record is five groups of sixteen channels of address, data and status.
// - the write strobe sits on channel 4 of the fifth group.
// - the read-word enable sits on channel 5 of the fifth group.
// - both diagnostic outputs of the cpu are stored in each record.
// - on a cacheable read, diag 1 high, diag 0 high marks a fetch and low a data load.
// - a falsely triggered write is flagged as trigger error and reported as a store.
// - with the read-word enable held low through a burst only the first word is caught.
// - optionally word-index bit 0 (address bit 2) gated with read strobe gives a sample on each edge.
module btc_capture #(
  parameter int REC_W = `BTC_REC_W
) (
  input  wire logic                 core_clk_in,
  input  wire logic                 reset_in,
  input  wire btc_pkg::btc_cpu_t    cpu_in,
  input  wire logic                 subst_strobe_en_in,
  input  wire logic [31:0]          reg_addr_in,
  input  wire logic [31:0]          reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic [31:0]               reg_rdata_out,
  output btc_pkg::btc_record_t      record_out,
  output logic [2:0]                class_out,
  output logic                      record_valid_out,
  output logic                      irq_out
);
  import btc_pkg::*;

  btc_cpu_t    prev_reg;
  btc_record_t record_reg;
  btc_record_t rec_next;
  btc_state_t  state_reg;
  logic [2:0]  class_reg;
  logic [2:0]  class_next;
  logic        valid_reg;
  logic [`BTC_EV_N-1:0] status_reg;
  logic [`BTC_EV_N-1:0] enable_reg;
  logic [31:0] rdata_reg;
  logic        irq_reg;
  logic        rwe_fall;
  logic        wr_rise;
  logic        subst_edge;
  logic        take;
  logic        false_trig;
  logic [`BTC_EV_N-1:0] ev;

  // edge detect on the bus strobes
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prev_reg <= '1;
    end else begin
      prev_reg <= cpu_in;
    end
  end

  assign rwe_fall   = prev_reg.read_word_enable_n & ~cpu_in.read_word_enable_n
                      & ~cpu_in.read_n;
  assign wr_rise    = ~prev_reg.write_n & cpu_in.write_n;
  assign subst_edge = subst_strobe_en_in & ~cpu_in.read_n & ~prev_reg.read_n
                      & (prev_reg.word_idx[0] ^ cpu_in.word_idx[0]);
  assign take       = rwe_fall | wr_rise | subst_edge;
  assign false_trig = wr_rise & ~prev_reg.read_word_enable_n;

  always_comb begin
    rec_next = '0;
    rec_next.g4 = cpu_in.bus_ad[31:16];
    rec_next.g3 = cpu_in.bus_ad[15:0];
    rec_next.g2 = cpu_in.addr_hi[27:12];
    rec_next.g1 = {cpu_in.addr_hi[11:0], cpu_in.word_idx, cpu_in.byte_lane_enables};
    rec_next.g5[`BTC_CH_WR_N]  = wr_rise ? prev_reg.write_n : cpu_in.write_n;
    rec_next.g5[`BTC_CH_RWE_N] = wr_rise ? prev_reg.read_word_enable_n
                                         : cpu_in.read_word_enable_n;
    rec_next.g5[`BTC_CH_DIAG1] = cpu_in.diag[1];
    rec_next.g5[`BTC_CH_DIAG0] = cpu_in.diag[0];
  end

  always_comb begin
    class_next = `BTC_CLASS_READ;
    if (wr_rise) begin
      class_next = false_trig ? `BTC_CLASS_TERR : `BTC_CLASS_WRITE;
    end else if (cpu_in.diag[1]) begin
      class_next = cpu_in.diag[0] ? `BTC_CLASS_IFETCH : `BTC_CLASS_DLOAD;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      record_reg <= `BTC_REC_RESET;
      class_reg  <= `BTC_CLASS_READ;
      valid_reg  <= 1'b0;
    end else begin
      valid_reg <= take;
      if (take) begin
        record_reg <= rec_next;
        class_reg  <= class_next;
      end
    end
  end

  // cycle tracking
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= BTC_IDLE;
    end else begin
      case (state_reg)
        BTC_IDLE:  state_reg <= ~cpu_in.read_n ? BTC_READ
                                : (~cpu_in.write_n ? BTC_WRITE : BTC_IDLE);
        BTC_READ:  state_reg <= cpu_in.read_n ? BTC_IDLE : BTC_READ;
        BTC_WRITE: state_reg <= cpu_in.write_n ? BTC_IDLE : BTC_WRITE;
        default:   state_reg <= BTC_IDLE;
      endcase
    end
  end

  assign ev[`BTC_EV_READ]  = rwe_fall;
  assign ev[`BTC_EV_WRITE] = wr_rise;
  assign ev[`BTC_EV_TERR]  = false_trig;
  assign ev[`BTC_EV_SUBST] = subst_edge;

  // sticky status, set beats clear
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      status_reg <= '0;
    end else if (reg_wr_in && reg_addr_in == 32'h8) begin
      status_reg <= (status_reg & ~reg_wdata_in[`BTC_EV_N-1:0]) | ev;
    end else begin
      status_reg <= status_reg | ev;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      enable_reg <= '0;
    end else if (reg_wr_in && reg_addr_in == 32'h4) begin
      enable_reg <= reg_wdata_in[`BTC_EV_N-1:0];
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & enable_reg);
    end
  end

  // register read, one cycle later
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_reg <= '0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        32'h0:   rdata_reg <= {28'h0, status_reg};
        32'h4:   rdata_reg <= {28'h0, enable_reg};
        32'hc:   rdata_reg <= {29'h0, class_reg};
        32'h10:  rdata_reg <= {record_reg.g4, record_reg.g3};
        32'h14:  rdata_reg <= {record_reg.g2, record_reg.g1};
        32'h18:  rdata_reg <= {16'h0, record_reg.g5};
        default: rdata_reg <= 32'h0;
      endcase
    end else begin
      rdata_reg <= 32'h0;
    end
  end

  assign reg_rdata_out    = rdata_reg;
  assign record_out       = record_reg;
  assign class_out        = class_reg;
  assign record_valid_out = valid_reg;
  assign irq_out          = irq_reg;

  sequence s_write_edge;
    !prev_reg.write_n && cpu_in.write_n;
  endsequence

  sequence s_read_edge;
    prev_reg.read_word_enable_n && !cpu_in.read_word_enable_n && !cpu_in.read_n;
  endsequence

  sequence s_subst_edge;
    subst_strobe_en_in && !cpu_in.read_n && !prev_reg.read_n
      && (prev_reg.word_idx[0] != cpu_in.word_idx[0]);
  endsequence

  sequence s_write_rec;
    valid_reg && record_reg.g5[`BTC_CH_WR_N] == 1'b0;
  endsequence

  sequence s_read_rec;
    valid_reg && record_reg.g5[`BTC_CH_WR_N] && !record_reg.g5[`BTC_CH_RWE_N];
  endsequence

  a_write_sample: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_write_edge |=> s_write_rec)
    else $error("write edge not captured");

  a_false_trig: assert property (@(posedge core_clk_in) disable iff (reset_in)
    false_trig |=> class_reg == `BTC_CLASS_TERR && !record_reg.g5[`BTC_CH_RWE_N])
    else $error("false trigger not flagged");

  a_read_word: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_read_edge |=> valid_reg && record_reg.g3 == $past(cpu_in.bus_ad[15:0]))
    else $error("read word not captured");

  a_read_rec: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_read_edge ##0 cpu_in.write_n |=> s_read_rec)
    else $error("read record strobe channels wrong");

  a_fetch_class: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (rwe_fall && !wr_rise && cpu_in.diag == 2'b11) |=> class_reg == `BTC_CLASS_IFETCH)
    else $error("fetch misclassed");

  a_load_class: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (rwe_fall && !wr_rise && cpu_in.diag == 2'b10) |=> class_reg == `BTC_CLASS_DLOAD)
    else $error("load misclassed");

  a_plain_class: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (rwe_fall && !wr_rise && !cpu_in.diag[1]) |=> class_reg == `BTC_CLASS_READ)
    else $error("read misclassed");

  a_write_class: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_write_edge ##0 prev_reg.read_word_enable_n |=> class_reg == `BTC_CLASS_WRITE)
    else $error("write misclassed");

  a_store_data: assert property (@(posedge core_clk_in) disable iff (reset_in)
    false_trig |=> {record_reg.g4, record_reg.g3} == $past(cpu_in.bus_ad))
    else $error("trigger error lost store data");

  a_bus_high: assert property (@(posedge core_clk_in) disable iff (reset_in)
    take |=> record_reg.g4 == $past(cpu_in.bus_ad[31:16]))
    else $error("upper bus half wrong");

  a_addr_hi: assert property (@(posedge core_clk_in) disable iff (reset_in)
    take |=> record_reg.g2 == $past(cpu_in.addr_hi[27:12]))
    else $error("upper address wrong");

  a_addr_lo: assert property (@(posedge core_clk_in) disable iff (reset_in)
    take |=> record_reg.g1 == $past({cpu_in.addr_hi[11:0], cpu_in.word_idx,
                                     cpu_in.byte_lane_enables}))
    else $error("lower address group wrong");

  a_diag_chan: assert property (@(posedge core_clk_in) disable iff (reset_in)
    take |=> record_reg.g5[`BTC_CH_DIAG1] == $past(cpu_in.diag[1])
             && record_reg.g5[`BTC_CH_DIAG0] == $past(cpu_in.diag[0]))
    else $error("diagnostic channels wrong");

  a_spare_chan: assert property (@(posedge core_clk_in) disable iff (reset_in)
    valid_reg |-> record_reg.g5[15:13] == 3'h0 && !record_reg.g5[11]
                  && record_reg.g5[9:6] == 4'h0 && record_reg.g5[3:0] == 4'h0)
    else $error("spare status channel set");

  a_write_rwe: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_write_edge |=> record_reg.g5[`BTC_CH_RWE_N] == $past(prev_reg.read_word_enable_n))
    else $error("enable level on write wrong");

  a_subst_word: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_subst_edge |=> valid_reg && record_reg.g3 == $past(cpu_in.bus_ad[15:0]))
    else $error("substitute word not captured");

  a_subst_state: assert property (@(posedge core_clk_in) disable iff (reset_in)
    subst_edge |-> state_reg == BTC_READ)
    else $error("substitute sample outside read");

  a_write_state: assert property (@(posedge core_clk_in) disable iff (reset_in)
    wr_rise |-> state_reg == BTC_WRITE)
    else $error("write sample outside write");

  a_no_extra: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !take |=> !valid_reg && $stable(record_reg))
    else $error("sample without strobe");

  a_enable_rise: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (!prev_reg.read_word_enable_n && cpu_in.read_word_enable_n && prev_reg.write_n
     && !subst_edge) |=> !valid_reg)
    else $error("sample on enable release");

  a_enable_held: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (!prev_reg.read_word_enable_n && !cpu_in.read_word_enable_n && !subst_edge
     && !wr_rise) |=> !valid_reg)
    else $error("sample while enable held");

  // sticky status set wins
  a_status_sticky: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ev != '0 |=> (status_reg & $past(ev)) == $past(ev))
    else $error("status event lost");

  // interrupt raised
  a_irq_set: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (status_reg & enable_reg) != '0 |=> irq_reg)
    else $error("interrupt not raised");

  // interrupt dropped
  a_irq_clear: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (status_reg & enable_reg) == '0 |=> !irq_reg)
    else $error("interrupt not dropped");

  // read data only after a read
  a_rdata_idle: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !reg_rd_in |=> rdata_reg == 32'h0)
    else $error("read data outside read slot");
endmodule : btc_capture
`default_nettype wire
